// *** core/bnv_defs.svh ***
// Timing and width constants for the bytewide nonvolatile RAM host.
// Assumes a 40 MHz core clock; counts are derived from ns figures.
`ifndef BNV_DEFS_SVH
`define BNV_DEFS_SVH

`define BNV_CLK_PERIOD_NS 25
// Access: chip select low to data valid, and least low time
`define BNV_T_ACCESS_NS   120
// Least precharge (chip select high) time
`define BNV_T_PRECH_NS    60
// Longest chip select low time
`define BNV_T_CA_MAX_NS   2000
// Least write strobe pulse width and data setup
`define BNV_T_WP_NS       40
`define BNV_T_DS_NS       40
// Least times round up, longest rounds down
`define BNV_CYC_UP(ns)   (((ns) + `BNV_CLK_PERIOD_NS - 1) / `BNV_CLK_PERIOD_NS)
`define BNV_CYC_DN(ns)   ((ns) / `BNV_CLK_PERIOD_NS)
`define BNV_ACC_CYC      `BNV_CYC_UP(`BNV_T_ACCESS_NS)
`define BNV_PRE_CYC      `BNV_CYC_UP(`BNV_T_PRECH_NS)
`define BNV_CA_MAX_CYC   `BNV_CYC_DN(`BNV_T_CA_MAX_NS)
`define BNV_WP_CYC       `BNV_CYC_UP(`BNV_T_WP_NS)
`define BNV_DS_CYC       `BNV_CYC_UP(`BNV_T_DS_NS)
// Least time after supply reaches minimum before first access
`define BNV_T_PU_NS      1000
`define BNV_PU_CYC       `BNV_CYC_UP(`BNV_T_PU_NS)
// Row size in bytes for endurance accounting
`define BNV_ROW_BYTES    4

`endif

// *** core/bnv_pkg.sv ***
// Types shared by the bytewide nonvolatile RAM host controller.
// Assumes the constants header is included where counts are needed.
package bnv_pkg;

  // Host request carried as one packed word
  typedef struct packed {
    logic        write;
    logic        ce_ctrl;   // Write strobe low before chip select falls
    logic [12:0] addr;
    logic [7:0]  data;
  } bnv_req_t;

  // Pins toward the memory
  typedef struct packed {
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic [12:0] address_inputs;
  } bnv_pins_t;

  typedef enum logic [2:0] {
    BNV_PWRUP,
    BNV_IDLE,
    BNV_SETUP,
    BNV_ACCESS,
    BNV_STROBE,
    BNV_PRECH
  } bnv_state_t;

endpackage : bnv_pkg

// *** core/bnv_host.sv ***
// Host controller driving a bytewide nonvolatile RAM through its pins.
// Assumes one 40 MHz clock, synchronous inputs, supply-good level input.
//
// What this block does
// - Write strobe low before chip select falls gives a chip-select write.
// - Write data stays stable for the setup time before the write ends.
// - Chip select stays high at least the precharge time between accesses.
// - Chip select never stays low longer than the longest low time.
// - Every access starts with its own falling edge of chip select.
// - No access is accepted while supply is below its minimum; one already accepted runs to its end, even if supply drops during its setup cycle.
`timescale 1ns/1ps
`include "bnv_defs.svh"

module bnv_host
  import bnv_pkg::*;
#(
  parameter int PU_CYC = `BNV_PU_CYC
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // Supply monitor level, high when supply is within tolerance
  input  wire logic        i_supply_ok,
  // Request side
  input  wire logic        i_req_valid,
  input  wire bnv_req_t    i_req,
  output logic             o_req_ready,
  output logic             o_rd_valid,
  output logic [7:0]       o_rd_data,
  // Last accessed row index, for endurance tracking
  output logic [10:0]      o_row_reg,
  output logic             o_row_hit,
  // Memory pins
  output bnv_pins_t        o_pins,
  input  wire logic [7:0]  i_data_lines,
  output logic [7:0]       o_data_lines,
  output logic             o_data_lines_oe_n
);

  localparam int CW = 12;
  localparam logic [CW-1:0] ACC_C = CW'(`BNV_ACC_CYC);
  localparam logic [CW-1:0] PRE_C = CW'(`BNV_PRE_CYC);
  localparam logic [CW-1:0] WP_C  = CW'(`BNV_WP_CYC);
  localparam logic [CW-1:0] CAX_C = CW'(`BNV_CA_MAX_CYC);
  localparam int ROW_SH = $clog2(`BNV_ROW_BYTES);

  bnv_state_t      state_reg;
  bnv_req_t        req_reg;
  logic [CW-1:0]   cnt_reg;
  logic [CW-1:0]   low_reg;
  logic [15:0]     pu_reg;
  logic            ce_low;

  // Row of a byte address
  function automatic logic [10:0] row_of(input logic [12:0] a);
    row_of = a[12:ROW_SH];
  endfunction : row_of

  //--------------------------------------------------------------
  // Sequencer
  //--------------------------------------------------------------
  assign o_req_ready = (state_reg == BNV_IDLE) && i_supply_ok;

  // Phase timing and request capture
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_reg <= BNV_PWRUP;
      cnt_reg   <= '0;
      pu_reg    <= '0;
      req_reg   <= '0;
    end else begin
      unique case (state_reg)
        BNV_PWRUP: begin
          // Wait for supply settle before the first access
          if (!i_supply_ok) pu_reg <= '0;
          else if (pu_reg == 16'(PU_CYC)) state_reg <= BNV_IDLE;
          else pu_reg <= pu_reg + 16'h0001;
        end
        BNV_IDLE: begin
          if (!i_supply_ok) begin
            state_reg <= BNV_PWRUP;
            pu_reg    <= '0;
          end else if (i_req_valid) begin
            req_reg   <= i_req;
            state_reg <= BNV_SETUP;
          end
        end
        // One cycle of address and strobe setup, chip select still high
        BNV_SETUP: begin
          state_reg <= BNV_ACCESS;
          cnt_reg   <= '0;
        end
        BNV_ACCESS: begin
          cnt_reg <= cnt_reg + 12'h001;
          // Strobe-controlled write: drop strobe early enough for a full pulse
          if (req_reg.write && !req_reg.ce_ctrl
              && cnt_reg == ACC_C - WP_C - 12'h001) begin
            state_reg <= BNV_STROBE;
            cnt_reg   <= '0;
          end else if (cnt_reg == ACC_C - 12'h001) begin
            state_reg <= BNV_PRECH;
            cnt_reg   <= '0;
          end
        end
        BNV_STROBE: begin
          cnt_reg <= cnt_reg + 12'h001;
          if (cnt_reg == WP_C - 12'h001) begin
            state_reg <= BNV_PRECH;
            cnt_reg   <= '0;
          end
        end
        BNV_PRECH: begin
          cnt_reg <= cnt_reg + 12'h001;
          if (cnt_reg == PRE_C - 12'h001) begin
            state_reg <= BNV_IDLE;
          end
        end
        default: state_reg <= BNV_PWRUP;
      endcase
    end
  end

  assign ce_low = (state_reg == BNV_ACCESS) || (state_reg == BNV_STROBE);

  //--------------------------------------------------------------
  // Pin drive
  //--------------------------------------------------------------
  // Control pins; strobe and chip select rise together at write end
  always_comb begin
    o_pins.ce_n = !ce_low;
    o_pins.address_inputs = req_reg.addr;
    o_pins.we_n = 1'b1;
    o_pins.oe_n = 1'b1;
    if (req_reg.write && req_reg.ce_ctrl
        && (state_reg == BNV_SETUP || ce_low)) begin
      o_pins.we_n = 1'b0;
    end
    if (req_reg.write && state_reg == BNV_STROBE) begin
      o_pins.we_n = 1'b0;
    end
    // Output gate only for reads; it never picks the cycle type
    if (!req_reg.write && ce_low) begin
      o_pins.oe_n = 1'b0;
    end
  end

  // Host drives data through the whole write, stable ahead of its end
  assign o_data_lines = req_reg.data;
  assign o_data_lines_oe_n = !(req_reg.write
                               && (state_reg == BNV_SETUP || ce_low));

  // Longest chip select low watchdog counter
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) low_reg <= '0;
    else if (ce_low) low_reg <= low_reg + 12'h001;
    else low_reg <= '0;
  end

  //--------------------------------------------------------------
  // Read capture and endurance row
  //--------------------------------------------------------------
  // Sample at end of access time, when data is known valid
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= '0;
    end else begin
      o_rd_valid <= 1'b0;
      if (state_reg == BNV_ACCESS && !req_reg.write
          && cnt_reg == ACC_C - 12'h001) begin
        o_rd_valid <= 1'b1;
        o_rd_data  <= i_data_lines;
      end
    end
  end

  // Row touched by the last access; hit flags a repeat on one row
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_row_reg <= '0;
      o_row_hit <= 1'b0;
    end else if (state_reg == BNV_SETUP) begin
      o_row_hit <= (row_of(req_reg.addr) == o_row_reg);
      o_row_reg <= row_of(req_reg.addr);
    end
  end

  //--------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------
  a_ce_max_low: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    low_reg <= CAX_C) else $error("chip select low too long");
  a_prech_min: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(o_pins.ce_n) |-> o_pins.ce_n [*3])
    else $error("precharge too short");
  a_ce_fall_sep: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $fell(o_pins.ce_n) |-> $past(o_pins.ce_n, 2))
    else $error("chip select fall without high period");
  a_ce_ctrl_we: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ($fell(o_pins.ce_n) && req_reg.write && req_reg.ce_ctrl)
    |-> $past(!o_pins.we_n)) else $error("strobe not low first");
  a_we_late: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ($fell(o_pins.ce_n) && req_reg.write && !req_reg.ce_ctrl)
    |-> o_pins.we_n [*3] ##1 !o_pins.we_n [*2])
    else $error("strobe timing wrong");
  a_addr_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !o_pins.ce_n |-> $stable(o_pins.address_inputs))
    else $error("address moved while selected");
  a_data_setup: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ($rose(o_pins.ce_n) && req_reg.write)
    |-> $past(!o_data_lines_oe_n, 2) && $stable(o_data_lines))
    else $error("write data not set up");
  a_no_oe_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !o_data_lines_oe_n |-> o_pins.oe_n)
    else $error("bus fight on data lines");
  a_supply_gate: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (state_reg == BNV_IDLE && !i_supply_ok) |=> o_pins.ce_n)
    else $error("access while supply low");
  a_read_done: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    ($fell(o_pins.ce_n) && !req_reg.write) |-> ##5 o_rd_valid)
    else $error("read not captured on time");

  c_ce_write: cover property (@(posedge i_core_clk)
    $fell(o_pins.ce_n) && req_reg.write && req_reg.ce_ctrl);
  c_we_write: cover property (@(posedge i_core_clk) $fell(o_pins.we_n)
    && !o_pins.ce_n);
  c_read: cover property (@(posedge i_core_clk) o_rd_valid);
  c_row_hit: cover property (@(posedge i_core_clk) o_row_hit);

endmodule : bnv_host

// *** verification/bnv_mem_model.sv ***
// Behavioural model of the bytewide nonvolatile RAM seen by the host.
// Assumes pins come from the host controller; timing is checked in ns.
`timescale 1ns/1ps
module bnv_mem_model #(
  parameter realtime T_ACC = 120,
  parameter realtime T_PC  = 60,
  parameter realtime T_MAX = 2000,
  parameter realtime T_DS  = 40
) (
  // Pins from the host
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic [12:0] i_addr,
  input  wire logic [7:0]  i_dq,
  // Data back, row seen and timing faults
  output logic [7:0]       o_dq,
  output logic             o_dq_oe_n,
  output int               o_viol,
  output logic [10:0]      o_row
);
  logic [7:0]  mem [0:8191];
  logic [12:0] lat_addr;
  logic        wr_cyc = 1'b0;
  logic        wr_open = 1'b0;
  logic        acc_ok = 1'b0;
  realtime     t_fall = -1.0;
  realtime     t_rise = -1000.0;
  realtime     t_dq = 0.0;
  initial o_viol = 0;
  always @(i_dq) t_dq = $realtime;
  // Falling edge latches address; no supply gating at all
  always @(negedge i_ce_n) begin
    lat_addr = i_addr;
    o_row = i_addr[12:2];
    wr_cyc = !i_we_n;
    wr_open = !i_we_n;
    acc_ok = 1'b0;
    t_fall = $realtime;
    if ($realtime - t_rise < T_PC) o_viol++;
  end
  // Strobe falling after select turns the read into a write
  always @(negedge i_we_n) if (!i_ce_n) begin
    wr_cyc = 1'b1;
    wr_open = 1'b1;
  end
  // First rising edge closes the write; data must have settled
  always @(posedge i_we_n or posedge i_ce_n) if (wr_open) begin
    wr_open = 1'b0;
    if ($realtime - t_dq < T_DS) o_viol++;
    mem[lat_addr] = i_dq;
  end
  // Precharge starts only here; low time must stay in bounds
  always @(posedge i_ce_n) if (t_fall >= 0.0) begin
    t_rise = $realtime;
    acc_ok = 1'b0;
    if (t_rise - t_fall > T_MAX || t_rise - t_fall < T_ACC) o_viol++;
  end
  // Output held back until access time has run out
  always @(negedge i_ce_n) begin
    #(T_ACC);
    if (!i_ce_n && !wr_cyc) acc_ok = 1'b1;
  end
  assign o_dq_oe_n = !(!i_ce_n && !i_oe_n && !wr_cyc && acc_ok);
  assign o_dq = mem[lat_addr];
endmodule : bnv_mem_model

// *** verification/bnv_host_test.sv ***
// Self-checking bench for the bytewide nonvolatile RAM host controller.
// Assumes the memory model beside it and a shortened power-up count.
`timescale 1ns/1ps
module bnv_host_test;
  import bnv_pkg::*;
  logic        core_clk, rst_n, supply_ok, req_valid, prev_ok;
  logic        ready, rd_valid, row_hit, dut_oe_n, mem_oe_n;
  bnv_req_t    req;
  bnv_pins_t   pins;
  logic [7:0]  rd_data, dut_dq, mem_dq, bus_last, shadow [0:8191];
  logic [10:0] row_reg, mem_row, prev_row;
  logic [31:0] rnd;
  int          err_count, cmp_count, viol, fight, cyc;
  logic [12:0] corner [5] = '{13'h0000, 13'h0003, 13'h0004, 13'h0007,
                              13'h1FFF};
  // Released bus shows the inverse of its last driven value
  // Bus settles 1 ns after its drivers, so a release never races a rise
  wire  [7:0]  dq;
  assign #1 dq = !mem_oe_n ? mem_dq : !dut_oe_n ? dut_dq : ~bus_last;

  bnv_host #(.PU_CYC(2)) u_dut (
    .i_core_clk(core_clk), .i_rst_n(rst_n), .i_supply_ok(supply_ok),
    .i_req_valid(req_valid), .i_req(req), .o_req_ready(ready),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_row_reg(row_reg),
    .o_row_hit(row_hit), .o_pins(pins), .i_data_lines(dq),
    .o_data_lines(dut_dq), .o_data_lines_oe_n(dut_oe_n));
  bnv_mem_model u_mem (
    .i_ce_n(pins.ce_n), .i_we_n(pins.we_n), .i_oe_n(pins.oe_n),
    .i_addr(pins.address_inputs), .i_dq(dq), .o_dq(mem_dq),
    .o_dq_oe_n(mem_oe_n), .o_viol(viol), .o_row(mem_row));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(dq) if (!mem_oe_n || !dut_oe_n) bus_last = dq;
  // Bus fights and the run-time ceiling
  always @(posedge core_clk) begin
    cyc++;
    if (!mem_oe_n && !dut_oe_n) fight++;
    if (cyc == 12000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction : lfsr

  task automatic wait_ready();
    for (int n = 0; n < 60 && ready !== 1'b1; n++) begin
      @(posedge core_clk);
      #2;
    end
    chk(ready, 1'b1);
  endtask : wait_ready

  // One access, then read data and row accounting are checked
  task automatic access(input logic wr, cec, input logic [12:0] a,
                        input logic [7:0] d);
    wait_ready();
    req = '{wr, cec, a, d};
    req_valid = 1'b1;
    @(posedge core_clk);
    #2;
    req_valid = 1'b0;
    if (wr) shadow[a] = d;
    for (int n = 0; n < 12 && !wr && rd_valid !== 1'b1; n++) begin
      @(posedge core_clk);
      #2;
    end
    if (!wr) chk(rd_data, shadow[a]);
    wait_ready();
    chk(row_reg, a[12:2]);
    chk(mem_row, a[12:2]);
    if (prev_ok) chk(row_hit, a[12:2] == prev_row);
    prev_row = a[12:2];
    prev_ok = 1'b1;
  endtask : access

  initial begin
    {err_count, cmp_count, fight, cyc} = '0;
    {rst_n, req_valid, prev_ok} = '0;
    supply_ok = 1'b1;
    req = '0;
    bus_last = 8'h00;
    rnd = 32'h03C425E6;
    repeat (12) @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    // Array ends and a row boundary, both write forms
    for (int i = 0; i < 5; i++) begin
      access(1'b1, i[0], corner[i], 8'hA5 ^ i[7:0]);
      access(1'b0, 1'b0, corner[i], 8'h00);
    end
    $display("corner test done");
    // Random writes, each read back at once
    repeat (40) begin
      rnd = lfsr(rnd);
      access(1'b1, rnd[31], rnd[12:0], rnd[20:13]);
      access(1'b0, 1'b0, rnd[12:0], 8'h00);
    end
    $display("random test done");
    // Supply low: nothing may start even with a request pending
    wait_ready();
    supply_ok = 1'b0;
    req_valid = 1'b1;
    repeat (20) begin
      @(posedge core_clk);
      #2;
      chk(ready, 1'b0);
      chk(pins.ce_n, 1'b1);
    end
    req_valid = 1'b0;
    supply_ok = 1'b1;
    access(1'b0, 1'b0, corner[4], 8'h00);
    $display("supply test done");
    chk(viol, 0);
    chk(fight, 0);
    end_of_test();
  end
endmodule : bnv_host_test
